/* File: core_flags_model.sv */
// Integer core stand-in that presents carry, zero and parity flags to the fp unit.
// Assumes the bench asks for a flag set at least two edges before the command write.
`timescale 1ns/1ps
`default_nettype none
module core_flags_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [2:0] flag_req,
	output logic carry_flag,
	output logic zero_flag,
	output logic parity_flag
);
	// flags move only on the core clock, like a real result write-back
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{carry_flag, zero_flag, parity_flag} <= 3'h0;
		end else begin
			{carry_flag, zero_flag, parity_flag} <= flag_req;
		end
	end
endmodule
`default_nettype wire

/* File: fp_stack_transfer_unit.sv */
// Fp register stack with loads, stores, pops, exchange and conditional move.
// Assumes an apb master on clk and integer status flags on the same clock.
//
// Chosen here: the register addresses and the APB register port.
`include "fp_xfer_map.svh"
`timescale 1ns/1ps
`default_nettype none
module fp_stack_transfer_unit (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic carry_flag,
	input wire logic zero_flag,
	input wire logic parity_flag
);
	import fp_xfer_pkg::*;

	// extended field access
	function automatic logic [14:0] exp_of(input ext_t v);
		return v[`EXP_HI:`EXP_LO];
	endfunction

	function automatic cls_t classify(input ext_t v);
		logic [14:0] e;
		e = exp_of(v);
		if (!v[`INT_BIT] && e != '0) begin
			if (e == `EXP_ONES) begin
				return (v[`INT_BIT-1:0] != '0) ? CL_PNAN : CL_PINF;
			end
			return CL_UNNORM;
		end
		if (e == '0 && v[`INT_BIT]) begin
			return CL_PDEN;
		end
		return CL_NUM;
	endfunction

	// a pseudo-denormal has the same value as exponent one with the bit set
	function automatic ext_t fix_pd(input ext_t v);
		ext_t r;
		r = v;
		if (exp_of(v) == '0 && v[`INT_BIT]) begin
			r[`EXP_LO] = 1'b1;
		end
		return r;
	endfunction

	// normalise a magnitude whose bit 63 would carry exponent e63
	function automatic ext_t norm(input logic s, input logic [63:0] m, input logic [14:0] e63);
		logic [63:0] t;
		logic [14:0] e;
		t = m;
		e = e63;
		if (m == '0) begin
			return {s, 79'h0};
		end
		for (int k = 0; k < 63; k++) begin
			if (!t[63]) begin
				t = t << 1;
				e = e - 15'h0001;
			end
		end
		return {s, e, t};
	endfunction

	// widen single or double; top bit flags a denormal source
	function automatic logic [80:0] flt_to_ext(input logic [63:0] o, input logic dbl);
		logic s;
		logic [10:0] e;
		logic [51:0] f;
		logic [14:0] rb;
		logic [10:0] mx;
		s = dbl ? o[63] : o[31];
		e = dbl ? o[62:52] : {3'h0, o[30:23]};
		f = dbl ? o[51:0] : {o[22:0], 29'h0};
		rb = dbl ? `DBL_REBIAS : `SGL_REBIAS;
		mx = dbl ? 11'h7FF : 11'h0FF;
		if (e == mx) begin
			return {1'b0, s, `EXP_ONES, 1'b1, f, 11'h0};
		end
		if (e == '0) begin
			return {f != '0, norm(s, {f, 12'h0}, rb)};
		end
		return {1'b0, s, rb + {4'h0, e}, 1'b1, f, 11'h0};
	endfunction

	// narrow to single or double by truncation, saturating range
	function automatic logic [63:0] ext_to_flt(input ext_t v, input logic dbl);
		logic [14:0] e;
		logic [14:0] rb;
		logic [14:0] mx;
		logic [14:0] ee;
		logic [51:0] f;
		e = exp_of(v);
		rb = dbl ? `DBL_REBIAS : `SGL_REBIAS;
		mx = dbl ? `DBL_EMAX : `SGL_EMAX;
		ee = e - rb;
		f = v[62:11];
		if (e == `EXP_ONES) begin
			ee = mx;
		end else if (e <= rb) begin
			ee = '0;
			f = '0;
		end else if (ee >= mx) begin
			ee = mx;
			f = '0;
		end
		if (dbl) begin
			return {v[`SIGN_BIT], ee[10:0], f};
		end
		return {32'h0, v[`SIGN_BIT], ee[7:0], f[51:29]};
	endfunction

	// truncated magnitude; top bit flags an invalid source or overflow
	function automatic logic [64:0] ext_mag(input ext_t v, input logic [14:0] lim);
		logic [14:0] e;
		logic [14:0] ub;
		e = exp_of(v);
		ub = e - `EXT_BIAS;
		if (e == `EXP_ONES || classify(v) != CL_NUM && classify(v) != CL_PDEN) begin
			return {1'b1, 64'h0};
		end
		if (e < `EXT_BIAS) begin
			return 65'h0;
		end
		if (ub > lim) begin
			return {1'b1, 64'h0};
		end
		return {1'b0, v[63:0] >> (`TOP_SH - ub)};
	endfunction

	function automatic logic [63:0] bcd_to_bin(input logic [71:0] d);
		logic [63:0] acc;
		acc = '0;
		for (int k = `BCD_DIGITS - 1; k >= 0; k--) begin
			acc = acc * 64'h0A + {60'h0, d[k*4 +: 4]};
		end
		return acc;
	endfunction

	function automatic logic [71:0] bin_to_bcd(input logic [63:0] b);
		logic [63:0] a;
		logic [71:0] d;
		a = b;
		d = '0;
		for (int k = 0; k < `BCD_DIGITS; k++) begin
			d[k*4 +: 4] = 4'(a % 64'h0A);
			a = a / 64'h0A;
		end
		return d;
	endfunction

	function automatic logic cc_true(input cc_t c, input logic cy, input logic zr, input logic py);
		case (c)
			CC_B: return cy;
			CC_NB: return !cy;
			CC_E: return zr;
			CC_NE: return !zr;
			CC_BE: return cy | zr;
			CC_NBE: return !(cy | zr);
			CC_U: return py;
			default: return !py;
		endcase
	endfunction

	logic [79:0] stk_ff [8];
	logic [7:0] valid_ff;
	logic [2:0] top_ff;
	logic [95:0] opnd_ff;
	logic [79:0] res_ff;
	logic inv_ff;
	logic den_ff;
	logic nesc_ff;
	logic took_ff;
	cls_t cls_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;

	// apb decode; access phase is always one cycle
	logic setup;
	logic hit;
	logic wr;
	assign setup = psel && !penable;
	assign hit = paddr <= `A_FEAT && paddr[1:0] == 2'h0;
	assign wr = psel && penable && pready_ff && pwrite && !pslverr_ff;

	// command decode from the write data of the ctrl access
	logic ctrl_wr;
	logic fp_escape_class;
	logic go;
	op_t op;
	fmt_t fmt;
	logic [2:0] sel;
	logic [2:0] top_dn;
	logic imask;
	assign ctrl_wr = wr && paddr == `A_CTRL;
	assign fp_escape_class = pwdata[`C_OPC_HI:`C_OPC_LO] >= `OPC_FP_LO
		&& pwdata[`C_OPC_HI:`C_OPC_LO] <= `OPC_FP_HI;
	assign go = ctrl_wr && fp_escape_class;
	assign op = op_t'(pwdata[`C_OP_HI:`C_OP_LO]);
	assign fmt = fmt_t'(pwdata[`C_FMT_HI:`C_FMT_LO]);
	assign imask = pwdata[`C_IMASK];
	assign sel = top_ff + pwdata[`C_IDX_HI:`C_IDX_LO];
	assign top_dn = top_ff - 3'h1;

	// memory operand held in little-endian words, byte 0 lowest
	ext_t mem_ext;
	ext_t top_v;
	ext_t sel_v;
	assign mem_ext = opnd_ff[79:0];
	assign top_v = stk_ff[top_ff];
	assign sel_v = stk_ff[sel];

	// load side: only stack or memory sources exist, no immediate path
	logic [80:0] widened;
	logic [63:0] ld_int;
	logic ld_neg;
	cls_t ld_cls;
	ext_t push_val;
	logic ld_inv;
	logic ld_den;
	always_comb begin
		widened = flt_to_ext(opnd_ff[63:0], fmt == FMT_D64);
		ld_int = (fmt == FMT_S32) ? {{32{opnd_ff[31]}}, opnd_ff[31:0]} : opnd_ff[63:0];
		ld_neg = ld_int[63];
		ld_cls = classify(mem_ext);
		ld_inv = 1'b0;
		ld_den = 1'b0;
		push_val = '0;
		case (op)
			OP_LDF: begin
				if (fmt == FMT_EXT) begin
					ld_inv = ld_cls != CL_NUM && ld_cls != CL_PDEN;
					ld_den = ld_cls == CL_PDEN;
					push_val = ld_inv ? `QNAN_INDEF : mem_ext;
				end else begin
					ld_den = widened[80];
					push_val = widened[79:0];
				end
			end
			OP_LDR: push_val = sel_v;
			OP_ILD: push_val = norm(ld_neg, ld_neg ? -ld_int : ld_int, `INT_E63);
			OP_BLD: push_val = norm(opnd_ff[79], bcd_to_bin(opnd_ff[71:0]), `INT_E63);
			default: push_val = '0;
		endcase
	end

	// store side conversions of the top value
	logic [64:0] imag;
	logic [64:0] bmag;
	logic st_inv;
	logic [79:0] st_val;
	logic [63:0] ineg;
	always_comb begin
		imag = ext_mag(top_v, fmt == FMT_S32 ? `I32_MAXSH : `I64_MAXSH);
		bmag = ext_mag(top_v, `I64_MAXSH);
		ineg = top_v[`SIGN_BIT] ? -imag[63:0] : imag[63:0];
		st_inv = 1'b0;
		st_val = '0;
		case (op)
			OP_STF, OP_STFP: begin
				st_val = (fmt == FMT_EXT) ? top_v : {16'h0, ext_to_flt(top_v, fmt == FMT_D64)};
			end
			OP_IST, OP_ISTP: begin
				st_inv = imag[64];
				if (fmt == FMT_S32) begin
					st_val = {48'h0, imag[64] ? `I32_INDEF : ineg[31:0]};
				end else begin
					st_val = {16'h0, imag[64] ? `INT_INDEF : ineg};
				end
			end
			OP_BSTP: begin
				st_inv = bmag[64] || bmag[63:0] >= `BCD_LIMIT;
				st_val = st_inv ? `BCD_INDEF : {top_v[`SIGN_BIT], 7'h0, bin_to_bcd(bmag[63:0])};
			end
			default: st_val = '0;
		endcase
	end

	logic is_push;
	logic is_pop;
	logic is_store;
	logic push_ok;
	logic cond;
	assign is_push = op == OP_LDF || op == OP_LDR || op == OP_ILD || op == OP_BLD;
	assign is_pop = op == OP_STFP || op == OP_ISTP || op == OP_BSTP || op == OP_STPR;
	assign is_store = op == OP_STF || op == OP_STFP || op == OP_IST || op == OP_ISTP
		|| op == OP_BSTP;
	assign push_ok = is_push && !(ld_inv && !imask);
	assign cond = cc_true(cc_t'(pwdata[`C_CC_HI:`C_CC_LO]), carry_flag, zero_flag, parity_flag);

	// register stack contents; every write path except OP_XCH passes through fix_pd
	always_ff @(posedge clk) begin
		if (go) begin
			case (op)
				OP_LDF, OP_LDR, OP_ILD, OP_BLD: begin
					if (push_ok) begin
						stk_ff[top_dn] <= fix_pd(push_val);
					end
				end
				OP_STPR: stk_ff[sel] <= fix_pd(top_v);
				OP_XCH: begin
					stk_ff[sel] <= top_v;
					stk_ff[top_ff] <= sel_v;
				end
				OP_CMOV: begin
					if (cond) begin
						stk_ff[top_ff] <= fix_pd(sel_v);
					end
				end
				default: ;
			endcase
		end
	end

	// top pointer and tags; a pop after a copy onto top leaves it empty
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			top_ff <= 3'h0;
			valid_ff <= 8'h00;
		end else if (go) begin
			if (push_ok) begin
				top_ff <= top_dn;
				valid_ff[top_dn] <= 1'b1;
			end else if (is_pop && !(st_inv && !imask)) begin
				if (op == OP_STPR) begin
					valid_ff[sel] <= 1'b1;
				end
				valid_ff[top_ff] <= 1'b0;
				top_ff <= top_ff + 3'h1;
			end else if (op == OP_XCH) begin
				valid_ff[sel] <= valid_ff[top_ff];
				valid_ff[top_ff] <= valid_ff[sel];
			end else if (op == OP_CMOV && cond) begin
				valid_ff[top_ff] <= valid_ff[sel];
			end
		end
	end

	// store result; an unmasked invalid leaves the destination alone
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			res_ff <= '0;
		end else if (go && is_store && !(st_inv && !imask)) begin
			res_ff <= st_val;
		end
	end

	// sticky exception flags, set wins over a same-cycle clear
	logic clr;
	assign clr = wr && paddr == `A_STAT;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			inv_ff <= 1'b0;
			den_ff <= 1'b0;
			nesc_ff <= 1'b0;
			took_ff <= 1'b0;
			cls_ff <= CL_NUM;
		end else begin
			inv_ff <= (go && (ld_inv && op == OP_LDF || st_inv && is_store))
				|| (inv_ff && !(clr && pwdata[`S_INV]));
			den_ff <= (go && op == OP_LDF && ld_den)
				|| (den_ff && !(clr && pwdata[`S_DEN]));
			nesc_ff <= (ctrl_wr && !fp_escape_class) || (nesc_ff && !(clr && pwdata[`S_NESC]));
			if (go && op == OP_CMOV) begin
				took_ff <= cond;
			end
			if (go && op == OP_LDF && fmt == FMT_EXT) begin
				cls_ff <= ld_cls;
			end
		end
	end

	// operand words written by software
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			opnd_ff <= '0;
		end else if (wr) begin
			case (paddr)
				`A_OPND0: opnd_ff[31:0] <= pwdata;
				`A_OPND1: opnd_ff[63:32] <= pwdata;
				`A_OPND2: opnd_ff[95:64] <= pwdata;
				default: ;
			endcase
		end
	end

	// read mux sampled in setup so prdata comes from a flop
	logic [31:0] rd;
	always_comb begin
		case (paddr)
			`A_CTRL: rd = '0;
			`A_OPND0: rd = opnd_ff[31:0];
			`A_OPND1: rd = opnd_ff[63:32];
			`A_OPND2: rd = opnd_ff[95:64];
			`A_RES0: rd = res_ff[31:0];
			`A_RES1: rd = res_ff[63:32];
			`A_RES2: rd = {16'h0, res_ff[79:64]};
			`A_STAT: rd = {11'h0, cls_ff, valid_ff, 1'b0, took_ff, nesc_ff, den_ff, inv_ff, top_ff};
			`A_FEAT: rd = {31'h0, `FEAT_CMOV};
			default: rd = '0;
		endcase
	end

	// zero-wait apb answer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup && !hit;
			if (setup) begin
				prdata_ff <= (hit && !pwrite) ? rd : 32'h0;
			end
		end
	end
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_push;
		go && push_ok;
	endsequence
	sequence s_pop;
		go && is_pop && !push_ok && !(st_inv && !imask);
	endsequence

	AST_APB_READY: assert property (setup |=> pready && pslverr == !$past(hit))
		else $error("pready or pslverr wrong after setup");
	AST_PUSH_TOP: assert property (s_push |=> top_ff == 3'($past(top_ff) - 3'h1)
		&& valid_ff[top_ff])
		else $error("push did not move top down");
	AST_POP_TOP: assert property (s_pop |=> top_ff == 3'($past(top_ff) + 3'h1)
		&& !valid_ff[$past(top_ff)])
		else $error("pop did not empty top and move up");
	AST_NON_ESCAPE: assert property (ctrl_wr && !fp_escape_class |=> $stable(top_ff)
		&& $stable(valid_ff) && nesc_ff)
		else $error("non-escape opcode changed the stack");
	AST_UNSUP_INV: assert property (go && op == OP_LDF && fmt == FMT_EXT
		&& (ld_cls == CL_PNAN || ld_cls == CL_PINF || ld_cls == CL_UNNORM) |=> inv_ff)
		else $error("unsupported operand did not raise invalid");
	AST_PDEN_DEN: assert property (go && op == OP_LDF && fmt == FMT_EXT && ld_cls == CL_PDEN
		|=> den_ff && cls_ff == CL_PDEN)
		else $error("pseudo-denormal did not raise denormal");
	AST_NO_PDEN: assert property (valid_ff[top_ff] |-> classify(top_v) != CL_PDEN)
		else $error("pseudo-denormal held on the stack");
	AST_CMOV_FALSE: assert property (go && op == OP_CMOV && !cond |=> $stable(top_ff)
		&& stk_ff[top_ff] == $past(top_v))
		else $error("false condition changed the top");
	AST_INT_INDEF: assert property (go && (op == OP_IST || op == OP_ISTP) && fmt == FMT_D64
		&& imag[64] && imask |=> res_ff[63:0] == `INT_INDEF)
		else $error("masked invalid store missed the indefinite");
	AST_FEAT_READ: assert property (setup && !pwrite && paddr == `A_FEAT
		|=> prdata[0] == `FEAT_CMOV)
		else $error("feature bit not reported");
endmodule
`default_nettype wire

/* File: fp_xfer_map.svh */
// Register offsets, field positions and encodings of the fp stack transfer unit.
// Definitions only; included by the unit itself and by its bench.
`ifndef FP_XFER_MAP_SVH
`define FP_XFER_MAP_SVH
// apb word offsets
`define A_CTRL 8'h00
`define A_OPND0 8'h04
`define A_OPND1 8'h08
`define A_OPND2 8'h0C
`define A_RES0 8'h10
`define A_RES1 8'h14
`define A_RES2 8'h18
`define A_STAT 8'h1C
`define A_FEAT 8'h20
// command word fields
`define C_OPC_HI 7
`define C_OPC_LO 0
`define C_IDX_HI 10
`define C_IDX_LO 8
`define C_OP_HI 14
`define C_OP_LO 11
`define C_FMT_HI 16
`define C_FMT_LO 15
`define C_CC_HI 19
`define C_CC_LO 17
`define C_IMASK 20
// status sticky bits, write one to clear
`define S_INV 3
`define S_DEN 4
`define S_NESC 5
// extended format fields
`define SIGN_BIT 79
`define EXP_HI 78
`define EXP_LO 64
`define INT_BIT 63
`define EXP_ONES 15'h7FFF
`define EXT_BIAS 15'h3FFF
`define SGL_REBIAS 15'h3F80
`define DBL_REBIAS 15'h3C00
`define INT_E63 15'h403E
`define SGL_EMAX 15'h00FF
`define DBL_EMAX 15'h07FF
`define I32_MAXSH 15'h001E
`define I64_MAXSH 15'h003E
`define TOP_SH 15'h003F
// escape opcode range
`define OPC_FP_LO 8'hD8
`define OPC_FP_HI 8'hDF
// special encodings
`define QNAN_INDEF 80'hFFFF_C000_0000_0000_0000
`define INT_INDEF 64'h8000_0000_0000_0000
`define I32_INDEF 32'h8000_0000
`define BCD_INDEF 80'h8000_0000_0000_0000_0000
`define BCD_LIMIT 64'h0DE0_B6B3_A764_0000
`define BCD_DIGITS 18
`define FEAT_CMOV 1'b1
`endif

/* File: fp_xfer_pkg.sv */
// Types shared by the fp stack transfer unit.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package fp_xfer_pkg;
	typedef logic [79:0] ext_t;
	typedef enum logic [3:0] {
		OP_LDF = 4'h0, OP_LDR = 4'h1, OP_ILD = 4'h2, OP_BLD = 4'h3,
		OP_STF = 4'h4, OP_STFP = 4'h5, OP_IST = 4'h6, OP_ISTP = 4'h7,
		OP_BSTP = 4'h8, OP_STPR = 4'h9, OP_XCH = 4'hA, OP_CMOV = 4'hB
	} op_t;
	typedef enum logic [2:0] {
		CC_B = 3'h0, CC_NB = 3'h1, CC_E = 3'h2, CC_NE = 3'h3,
		CC_BE = 3'h4, CC_NBE = 3'h5, CC_U = 3'h6, CC_NU = 3'h7
	} cc_t;
	typedef enum logic [1:0] {
		FMT_S32 = 2'h0, FMT_D64 = 2'h1, FMT_EXT = 2'h2
	} fmt_t;
	typedef enum logic [4:0] {
		CL_NUM = 5'h01, CL_PNAN = 5'h02, CL_PINF = 5'h04,
		CL_UNNORM = 5'h08, CL_PDEN = 5'h10
	} cls_t;
endpackage
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the fp stack transfer unit: table rows, then edge cases.
// Assumes the unit's apb map header and the flags model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "fp_xfer_map.svh"
module testbench import fp_xfer_pkg::*;;
	typedef struct {op_t op; fmt_t fmt; logic [2:0] idx; logic msk; ext_t v;
		logic [2:0] stk; logic [4:0] cls;} row_t;
	localparam ext_t EA = 80'h3FFF_8000_0000_0000_0000;
	localparam ext_t EB = 80'h4000_C000_0000_0000_0000;
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr, carry_w, zero_w, parity_w, err;
	logic [7:0] paddr, tags;
	logic [31:0] pwdata, prdata, q;
	logic [2:0] flag_req, top;
	ext_t r;
	int mismatches = 0;
	int checked = 0;
	int cyc = 0;
	logic [7:0] opcs [4] = '{8'hD7, 8'hD8, 8'hDF, 8'hE0};
	// loads carry their operand in v, stores their expected result
	row_t rows [] = '{
		'{OP_LDF, FMT_EXT, 0, 1, EA, 0, 1}, '{OP_STF, FMT_EXT, 0, 1, EA, 0, 0},
		'{OP_LDF, FMT_EXT, 0, 1, EB, 0, 1}, '{OP_XCH, FMT_EXT, 1, 1, 0, 0, 0},
		'{OP_STF, FMT_EXT, 0, 1, EA, 0, 0}, '{OP_LDR, FMT_EXT, 1, 1, 0, 0, 0},
		'{OP_STF, FMT_EXT, 0, 1, EB, 0, 0}, '{OP_STPR, FMT_EXT, 1, 1, 0, 0, 0},
		'{OP_STFP, FMT_EXT, 0, 1, EB, 0, 0}, '{OP_ILD, FMT_S32, 0, 1, 80'hFFFF_FFFB, 0, 0},
		'{OP_STF, FMT_EXT, 0, 1, 80'hC001_A000_0000_0000_0000, 0, 0},
		'{OP_ISTP, FMT_S32, 0, 1, 80'hFFFF_FFFB, 0, 0}, '{OP_BLD, FMT_EXT, 0, 1, 80'h25, 0, 0},
		'{OP_STF, FMT_EXT, 0, 1, 80'h4003_C800_0000_0000_0000, 0, 0},
		'{OP_BSTP, FMT_EXT, 0, 1, 80'h25, 0, 0}, '{OP_LDF, FMT_S32, 0, 1, 80'h3F80_0000, 0, 0},
		'{OP_STF, FMT_EXT, 0, 1, EA, 0, 0},
		'{OP_LDF, FMT_D64, 0, 1, 80'h4008_0000_0000_0000, 0, 0},
		'{OP_STFP, FMT_EXT, 0, 1, EB, 0, 0}, '{OP_STF, FMT_S32, 0, 1, 80'h3F80_0000, 0, 0},
		'{OP_LDF, FMT_EXT, 0, 1, 80'h7FFF_4000_0000_0000_0000, 1, 2},
		'{OP_STF, FMT_EXT, 0, 1, 80'hFFFF_C000_0000_0000_0000, 0, 0},
		'{OP_IST, FMT_S32, 0, 1, 80'h8000_0000, 1, 0},
		'{OP_IST, FMT_D64, 0, 1, 80'h8000_0000_0000_0000, 1, 0},
		'{OP_LDF, FMT_EXT, 0, 1, 80'h7FFF_0000_0000_0000_0000, 1, 4},
		'{OP_LDF, FMT_EXT, 0, 1, 80'h4000_4000_0000_0000_0000, 1, 8},
		'{OP_LDF, FMT_EXT, 0, 1, 80'h0000_8000_0000_0000_0001, 2, 16},
		'{OP_STF, FMT_EXT, 0, 1, 80'h0001_8000_0000_0000_0001, 0, 0},
		'{OP_LDF, FMT_EXT, 0, 0, 80'h7FFF_4000_0000_0000_0000, 1, 0}};

	fp_stack_transfer_unit dut_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .carry_flag(carry_w), .zero_flag(zero_w), .parity_flag(parity_w));
	core_flags_model core_u (.clk(clk), .arst_n(arst_n), .flag_req(flag_req),
		.carry_flag(carry_w), .zero_flag(zero_w), .parity_flag(parity_w));

	// 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// hang guard, far above the roughly one thousand cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic cmp(input ext_t got, input ext_t exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer; answer taken at the edge that samples pready high, then released
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// no own limit: only the hang guard ends a wait that never answers
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [31:0] mk(logic [7:0] opc, logic [2:0] cc, logic msk, fmt_t fmt,
		op_t op, logic [2:0] idx);
		return {11'h0, msk, cc, fmt, op, idx, opc};
	endfunction

	// top, tags and sticky flags against the bench's own stack model, then clear sticky
	task automatic chk_stat(input logic [2:0] stk, input logic [4:0] cls);
		apb(1'b0, `A_STAT, 32'h0);
		cmp(ext_t'({q[15:8], q[5:3], q[2:0]}), ext_t'({tags, stk, top}));
		if (cls != 5'h0) cmp(ext_t'(q[20:16]), ext_t'(cls));
		apb(1'b1, `A_STAT, 32'h38);
	endtask

	task automatic run_row(input row_t w);
		if (w.op inside {OP_LDF, OP_ILD, OP_BLD}) begin
			apb(1'b1, `A_OPND0, w.v[31:0]);
			apb(1'b1, `A_OPND1, w.v[63:32]);
			apb(1'b1, `A_OPND2, {16'h0, w.v[79:64]});
		end
		apb(1'b1, `A_CTRL, mk(8'hD9, 3'h0, w.msk, w.fmt, w.op, w.idx));
		if (w.msk && w.op inside {OP_LDF, OP_LDR, OP_ILD, OP_BLD}) begin
			top = top - 3'h1;
			tags[top] = 1'b1;
		end
		if (w.op inside {OP_STF, OP_STFP, OP_IST, OP_ISTP, OP_BSTP}) begin
			apb(1'b0, `A_RES0, 32'h0);
			r[31:0] = q;
			apb(1'b0, `A_RES1, 32'h0);
			r[63:32] = q;
			apb(1'b0, `A_RES2, 32'h0);
			r[79:64] = q[15:0];
			if (w.fmt == FMT_S32) cmp(ext_t'(r[31:0]), ext_t'(w.v[31:0]));
			else cmp(r, w.v);
		end
		if (w.op inside {OP_STFP, OP_ISTP, OP_BSTP, OP_STPR}) begin
			tags[top] = 1'b0;
			top = top + 3'h1;
		end
		chk_stat(w.stk, w.cls);
	endtask

	// flags requested from the core model, outcome worked out here
	task automatic cmov(input logic [2:0] cc, input logic [2:0] f);
		logic c, z, p, t;
		{c, z, p} = f;
		flag_req <= f;
		case (cc)
			3'h0: t = c;
			3'h1: t = !c;
			3'h2: t = z;
			3'h3: t = !z;
			3'h4: t = c | z;
			3'h5: t = !(c | z);
			3'h6: t = p;
			default: t = !p;
		endcase
		apb(1'b1, `A_CTRL, mk(8'hDE, cc, 1'b1, FMT_EXT, OP_CMOV, 3'h1));
		apb(1'b0, `A_STAT, 32'h0);
		cmp(ext_t'(q[6]), ext_t'(t));
	endtask

	initial begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		flag_req = 3'h0;
		top = 3'h0;
		tags = 8'h00;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		chk_stat(3'h0, 5'h0);
		apb(1'b0, `A_FEAT, 32'h0);
		cmp(ext_t'(q[0]), ext_t'(1'b1));
		apb(1'b0, 8'h24, 32'h0);
		cmp(ext_t'({err, q}), ext_t'({1'b1, 32'h0}));
		foreach (rows[i]) run_row(rows[i]);
		// opcode bytes on both sides of each end of the escape range
		foreach (opcs[i]) begin
			apb(1'b1, `A_CTRL, mk(opcs[i], 3'h0, 1'b1, FMT_EXT, OP_STF, 3'h0));
			chk_stat({opcs[i] < 8'hD8 || opcs[i] > 8'hDF, 2'b00}, 5'h0);
		end
		run_row('{OP_LDF, FMT_EXT, 0, 1, EA, 0, 1});
		run_row('{OP_LDF, FMT_EXT, 0, 1, EB, 0, 1});
		cmov(3'h0, 3'h0);
		run_row('{OP_STF, FMT_EXT, 0, 1, EB, 0, 0});
		for (int c = 0; c < 8; c++) begin
			for (int f = 0; f < 8; f++) cmov(c[2:0], f[2:0]);
		end
		run_row('{OP_STF, FMT_EXT, 0, 1, EA, 0, 0});
		// reset in mid-run empties the stack again
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		top = 3'h0;
		tags = 8'h00;
		chk_stat(3'h0, 5'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
